//--- rtl/fsu_pkg.sv
/*
 * Shared constants and types of the float subtract unit: register map,
 * status-word layout, flag positions, rounding modes and the pipe stage.
 * Assumes a 40 MHz core clock and a single AHB-Lite master.
 */
package fsu_pkg;

	////////////////////////////////////////////////////////////////////////
	// pipeline and issue
	localparam int         FSU_LATENCY = 3;
	localparam int         FSU_DEST_W  = 7;
	localparam logic [2:0] FSU_SLOT_A  = 3'h1;
	localparam logic [2:0] FSU_SLOT_B  = 3'h4;

	////////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam int          FSU_ADDR_W     = 12;
	localparam logic [11:0] FSU_OFF_STATUS = 12'h000;
	localparam logic [11:0] FSU_OFF_COUNT  = 12'h004;

	////////////////////////////////////////////////////////////////////////
	// flag vector, same layout in status word and query result
	localparam int FSU_FLAG_W  = 7;
	localparam int FSU_BIT_DIVIDE_BY_ZERO = 0;
	localparam int FSU_BIT_INEXACT        = 1;
	localparam int FSU_BIT_UNDERFLOW      = 2;
	localparam int FSU_BIT_OVERFLOW       = 3;
	localparam int FSU_BIT_INVALID        = 4;
	localparam int FSU_BIT_INPUT_FLUSH    = 5;
	localparam int FSU_BIT_OUTPUT_FLUSH   = 6;
	localparam int FSU_RM_LSB             = 8;

	localparam logic [6:0]  FSU_FLAGS_RST = 7'h00;
	localparam logic [31:0] FSU_COUNT_RST = 32'h0000_0000;
	localparam logic [31:0] FSU_QNAN      = 32'hffff_ffff;

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite encodings
	localparam logic [1:0] FSU_HTRANS_NONSEQ = 2'h2;
	localparam logic       FSU_HRESP_OKAY    = 1'b0;

	typedef enum logic [1:0] {
		FSU_RM_NEAREST = 2'h0,
		FSU_RM_ZERO    = 2'h1,
		FSU_RM_POS     = 2'h2,
		FSU_RM_NEG     = 2'h3
	} fsu_rmode_t;

	localparam fsu_rmode_t FSU_RM_RST = FSU_RM_NEAREST;

	typedef struct packed {
		logic                    valid;
		logic                    query;
		logic [FSU_DEST_W-1:0]   dest;
		logic [31:0]             data;
		logic [FSU_FLAG_W-1:0]   flags;
	} fsu_stage_t;

endpackage : fsu_pkg

//--- rtl/fsu_sub_core.sv
/*
 * Combinational single-precision subtract with flush-to-zero and flag
 * generation. Assumes the caller registers inputs and outputs.
 */
module fsu_sub_core (
	input  wire logic [31:0]                   first_source,
	input  wire logic [31:0]                   second_source,
	input  wire fsu_pkg::fsu_rmode_t           round_mode,
	output logic [31:0]                        difference,
	output logic [fsu_pkg::FSU_FLAG_W-1:0]     flags
);
	import fsu_pkg::*;

	logic [7:0]  ea, eb, e_big, d;
	logic [23:0] ma, mb, m_big, m_small, mant;
	logic        sa, sb, s_big, eff_sub, a_big;
	logic        a_den, b_den, a_nan, b_nan, a_snan, b_snan, a_inf, b_inf;
	logic [27:0] x_big, x_small, x_sh, sum, norm;
	logic [9:0]  e_n;
	logic [24:0] m_r;
	logic        inc, inexact, sticky;
	logic [4:0]  lz;

	function automatic logic [4:0] fsu_lzc(input logic [26:0] v);
		logic [4:0] n;
		logic       hit;
		n = 5'h00;
		hit = 1'b0;
		for (int i = 26; i >= 0; i--) begin
			if (!hit) begin
				if (v[i])
					hit = 1'b1;
				else
					n = n + 5'h01;
			end
		end
		return n;
	endfunction : fsu_lzc

	assign ea     = first_source[30:23];
	assign eb     = second_source[30:23];
	assign sa     = first_source[31];
	assign sb     = ~second_source[31];   // subtract as add of negation
	assign a_den  = (ea == 8'h00) && (|first_source[22:0]);
	assign b_den  = (eb == 8'h00) && (|second_source[22:0]);
	assign a_nan  = (ea == 8'hff) && (|first_source[22:0]);
	assign b_nan  = (eb == 8'hff) && (|second_source[22:0]);
	assign a_snan = a_nan && !first_source[22];
	assign b_snan = b_nan && !second_source[22];
	assign a_inf  = (ea == 8'hff) && !(|first_source[22:0]);
	assign b_inf  = (eb == 8'hff) && !(|second_source[22:0]);
	// denormals become zero here
	assign ma     = (ea == 8'h00) ? 24'h0 : {1'b1, first_source[22:0]}; // RL3
	assign mb     = (eb == 8'h00) ? 24'h0 : {1'b1, second_source[22:0]}; // RL3
	assign a_big  = {ea, ma} >= {eb, mb};
	assign e_big  = a_big ? ea : eb;
	assign m_big  = a_big ? ma : mb;
	assign m_small = a_big ? mb : ma;
	assign s_big  = a_big ? sa : sb;
	assign d      = a_big ? (ea - eb) : (eb - ea);
	assign eff_sub = sa ^ sb;

	always_comb begin
		difference = 32'h0;
		flags = '0;
		flags[FSU_BIT_INPUT_FLUSH] = a_den | b_den; // RL3
		x_big = {1'b0, m_big, 3'h0};
		x_small = {1'b0, m_small, 3'h0};
		sticky = 1'b0;
		if (d > 8'h1b) begin
			x_sh = {27'h0, |m_small};
		end else begin
			x_sh = x_small >> d;
			sticky = |(x_small & ~({28{1'b1}} << d));
			x_sh[0] = x_sh[0] | sticky;
		end
		sum = eff_sub ? (x_big - x_sh) : (x_big + x_sh); // RL1
		e_n = {2'h0, e_big};
		lz = 5'h00;
		if (sum[27]) begin
			norm = {1'b0, sum[27:2], sum[1] | sum[0]};
			e_n = e_n + 10'h001;
		end else begin
			lz = fsu_lzc(sum[26:0]);
			norm = sum << lz;
			e_n = e_n - {5'h00, lz};
		end
		inexact = norm[2] | norm[1] | norm[0];
		unique case (round_mode) // RL2
			FSU_RM_NEAREST: inc = norm[2] & (norm[1] | norm[0] | norm[3]);
			FSU_RM_ZERO:    inc = 1'b0;
			FSU_RM_POS:     inc = !s_big & inexact;
			FSU_RM_NEG:     inc = s_big & inexact;
		endcase
		m_r = {1'b0, norm[26:3]} + {24'h0, inc};
		mant = m_r[24] ? m_r[24:1] : m_r[23:0];
		if (m_r[24])
			e_n = e_n + 10'h001;

		if (a_nan || b_nan) begin
			// quiet input passes silently, signalling input is invalid
			difference = FSU_QNAN; // RL16
			flags[FSU_BIT_INVALID] = a_snan | b_snan; // RL16
		end else if (a_inf && b_inf) begin
			if (eff_sub) begin
				difference = FSU_QNAN; // RL16
				flags[FSU_BIT_INVALID] = 1'b1; // RL5
			end else begin
				difference = {sa, 8'hff, 23'h0};
			end
		end else if (a_inf) begin
			difference = {sa, 8'hff, 23'h0};
		end else if (b_inf) begin
			difference = {sb, 8'hff, 23'h0};
		end else if (sum == 28'h0) begin
			// exact cancellation: sign follows the rounding direction
			difference = {eff_sub ? (round_mode == FSU_RM_NEG) : s_big, 31'h0};
		end else if (e_n[9] || e_n == 10'h000) begin
			difference = {s_big, 31'h0}; // RL4
			flags[FSU_BIT_OUTPUT_FLUSH] = 1'b1; // RL4
			flags[FSU_BIT_UNDERFLOW] = 1'b1; // RL5
			flags[FSU_BIT_INEXACT] = 1'b1; // RL5
		end else if (e_n >= 10'h0ff) begin
			flags[FSU_BIT_OVERFLOW] = 1'b1; // RL5
			flags[FSU_BIT_INEXACT] = 1'b1; // RL5
			if (round_mode == FSU_RM_ZERO
			    || (round_mode == FSU_RM_POS && s_big)
			    || (round_mode == FSU_RM_NEG && !s_big))
				difference = {s_big, 8'hfe, 23'h7fffff}; // RL2
			else
				difference = {s_big, 8'hff, 23'h0};
		end else begin
			difference = {s_big, e_n[7:0], mant[22:0]}; // RL1
			flags[FSU_BIT_INEXACT] = inexact; // RL5
		end
	end

endmodule : fsu_sub_core

//--- rtl/fsu_float_subtract_unit.sv
/*
 * Float subtract unit: guarded subtract and flag-query operations with a
 * fixed three-cycle pipe, the sticky status word and an AHB-Lite slave
 * for software access. Assumes issue signals come from core logic on
 * SYS_CLK and that only one word-sized AHB master exists.
 */
// Local design decisions: the AHB-Lite slave port and the placing of the registers.

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// RL1: destination receives first source minus second source, single precision.
// RL2: rounding and flag evaluation follow the status-word rounding mode.
// RL3: denormal inputs become zero and set the input-flush flag.
// RL4: denormal results become zero and set the output-flush flag.
// RL5: every IEEE exception raised sets its matching status-word flag.
// RL6: status flags are sticky; only an explicit status write clears them.
// RL7: status flags update on the same edge the result is written.
// RL8: simultaneous flag updates are ORed together with the held value.
// RL9: subtract with guard low writes neither destination nor flags.
// RL10: flag query returns the flag vector and leaves status untouched.
// RL11: flag query treats denormal sources as zero and reports input-flush.
// RL12: flag query reports output-flush when the difference is denormal.
// RL13: flag query with guard low leaves the destination unchanged.
// RL14: bits 0..6 hold divzero,inexact,underflow,overflow,invalid,flushes; rest zero.
// RL15: issue from slots one or four only, result after three cycles.
// RL16: invalid cases give quiet NaN with invalid; quiet NaN input is silent.
module fsu_float_subtract_unit (
	input  wire logic                            SYS_CLK,
	input  wire logic                            RESET,
	// issue side
	input  wire logic                            ISSUE_VALID,
	input  wire logic                            ISSUE_QUERY,
	input  wire logic [2:0]                      ISSUE_SLOT,
	input  wire logic                            ISSUE_GUARD_LSB,
	input  wire logic [fsu_pkg::FSU_DEST_W-1:0]  ISSUE_DEST,
	input  wire logic [31:0]                     FIRST_SOURCE,
	input  wire logic [31:0]                     SECOND_SOURCE,
	output logic                                 ISSUE_REJECT,
	// writeback side
	output logic                                 WB_VALID,
	output logic [fsu_pkg::FSU_DEST_W-1:0]       WB_DEST,
	output logic [31:0]                          WB_DATA,
	// other float units updating the status word
	input  wire logic                            OTHER_FLAG_VALID,
	input  wire logic [fsu_pkg::FSU_FLAG_W-1:0]  OTHER_FLAGS,
	// status word as seen by the core
	output logic [fsu_pkg::FSU_FLAG_W-1:0]       STATUS_FLAGS,
	output fsu_pkg::fsu_rmode_t                  STATUS_ROUND_MODE,
	// AHB-Lite slave
	input  wire logic                            HSEL,
	input  wire logic [fsu_pkg::FSU_ADDR_W-1:0]  HADDR,
	input  wire logic [1:0]                      HTRANS,
	input  wire logic                            HWRITE,
	input  wire logic [2:0]                      HSIZE,
	input  wire logic [31:0]                     HWDATA,
	input  wire logic                            HREADY,
	output logic [31:0]                          HRDATA,
	output logic                                 HREADYOUT,
	output logic                                 HRESP
);
	import fsu_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		fsu_stage_t [FSU_LATENCY-1:0] pipe;
		logic [FSU_FLAG_W-1:0]        flags;
		fsu_rmode_t                   rmode;
		logic                         wr_pend;
		logic [FSU_ADDR_W-1:0]        wr_addr;
		logic [31:0]                  rdata;
		logic [31:0]                  done_count;
	} fsu_state_t;

	fsu_state_t            state_reg;
	fsu_state_t            state_next;

	logic [31:0]           core_diff;
	logic [FSU_FLAG_W-1:0] core_flags;
	logic                  slot_ok;
	logic                  issue_take;
	logic                  ahb_take;
	logic                  sub_retire;
	logic [FSU_FLAG_W-1:0] sub_update;
	logic [FSU_FLAG_W-1:0] other_update;
	logic [FSU_FLAG_W-1:0] base_flags;

	////////////////////////////////////////////////////////////////////////
	// arithmetic, rounding mode taken from the status word at issue

	fsu_sub_core fsu_sub_core_inst (
		.first_source  (FIRST_SOURCE),
		.second_source (SECOND_SOURCE),
		.round_mode    (state_reg.rmode), // RL2
		.difference    (core_diff),
		.flags         (core_flags)
	);

	////////////////////////////////////////////////////////////////////////
	// issue qualification

	// only the two float alu slots may feed this unit
	assign slot_ok = (ISSUE_SLOT == FSU_SLOT_A)
	                 || (ISSUE_SLOT == FSU_SLOT_B); // RL15
	// a false guard drops the operation outright, so nothing is written
	assign issue_take = ISSUE_VALID && slot_ok
	                    && ISSUE_GUARD_LSB; // RL9 RL13
	// rejected issue is reported back in the same cycle
	assign ISSUE_REJECT = ISSUE_VALID && !slot_ok; // RL15

	////////////////////////////////////////////////////////////////////////
	// status-word update terms

	// a subtract leaves the next-to-last stage on the edge that presents its
	// result, so flag and destination become visible together
	assign sub_retire = state_reg.pipe[FSU_LATENCY-2].valid
	                    && !state_reg.pipe[FSU_LATENCY-2].query; // RL7 RL10
	assign sub_update = sub_retire ?
	                    state_reg.pipe[FSU_LATENCY-2].flags : '0; // RL5
	assign other_update = OTHER_FLAG_VALID ? OTHER_FLAGS : '0; // RL8

	assign ahb_take = HSEL && HREADY && HTRANS[1];

	// the only path that can clear a flag is a software status write
	assign base_flags = (state_reg.wr_pend
	                     && state_reg.wr_addr == FSU_OFF_STATUS) ?
	                    HWDATA[FSU_FLAG_W-1:0] : state_reg.flags; // RL6

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		state_next = state_reg;

		// pipe entry: query results are the zero-extended flag vector
		state_next.pipe[0].valid = issue_take;
		state_next.pipe[0].query = ISSUE_QUERY;
		state_next.pipe[0].dest  = ISSUE_DEST;
		state_next.pipe[0].flags = core_flags;
		if (ISSUE_QUERY)
			state_next.pipe[0].data = {{(32-FSU_FLAG_W){1'b0}},
			                           core_flags}; // RL10 RL11 RL12 RL14
		else
			state_next.pipe[0].data = core_diff; // RL1
		for (int i = 1; i < FSU_LATENCY; i++)
			state_next.pipe[i] = state_reg.pipe[i-1]; // RL15

		// set wins over a same-cycle clear by software
		state_next.flags = base_flags | sub_update
		                   | other_update; // RL6 RL7 RL8

		if (state_reg.wr_pend && state_reg.wr_addr == FSU_OFF_STATUS)
			state_next.rmode = fsu_rmode_t'(HWDATA[FSU_RM_LSB+1:FSU_RM_LSB]);

		if (state_reg.pipe[FSU_LATENCY-2].valid)
			state_next.done_count = state_reg.done_count + 32'h1;

		// AHB address phase; the write lands in the following data phase
		state_next.wr_pend = ahb_take && HWRITE;
		state_next.wr_addr = HADDR;
		if (ahb_take && !HWRITE) begin
			// read mux uses next values so a just-written status word reads back
			unique case (HADDR)
				FSU_OFF_STATUS: begin
					state_next.rdata = 32'h0;
					state_next.rdata[FSU_FLAG_W-1:0] = state_next.flags;
					state_next.rdata[FSU_RM_LSB+1:FSU_RM_LSB] =
						state_next.rmode;
				end
				FSU_OFF_COUNT:
					state_next.rdata = state_next.done_count;
				default:
					state_next.rdata = 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			state_reg <= '0;
			state_reg.flags <= FSU_FLAGS_RST;
			state_reg.rmode <= FSU_RM_RST;
			state_reg.done_count <= FSU_COUNT_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign WB_VALID          = state_reg.pipe[FSU_LATENCY-1].valid;
	assign WB_DEST           = state_reg.pipe[FSU_LATENCY-1].dest;
	assign WB_DATA           = state_reg.pipe[FSU_LATENCY-1].data;
	assign STATUS_FLAGS      = state_reg.flags;
	assign STATUS_ROUND_MODE = state_reg.rmode;

	// zero wait state slave, always OKAY; size is not checked
	assign HRDATA    = state_reg.rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP     = FSU_HRESP_OKAY;

endmodule : fsu_float_subtract_unit

//--- testbench/fsu_core_rf.sv
/*
 * Register-file model of the core side: stores each writeback of the unit
 * and offers one read port to the bench.
 * Assumes writebacks come on the unit's clock, at most one per cycle.
 */
module fsu_core_rf (
	input  wire logic				clk,
	input  wire logic				rst,
	input  wire logic				wb_valid,
	input  wire logic [fsu_pkg::FSU_DEST_W-1:0]	wb_dest,
	input  wire logic [31:0]			wb_data,
	input  wire logic [fsu_pkg::FSU_DEST_W-1:0]	rd_addr,
	output logic [31:0]				rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	import fsu_pkg::*;
	logic [31:0]	rf_reg [2**FSU_DEST_W];
	// each entry starts as its own index, so a stray write shows
	always @(posedge clk) begin
		if (rst)
			foreach (rf_reg[i]) rf_reg[i] <= 32'(i);
		else if (wb_valid)
			rf_reg[wb_dest] <= wb_data;
	end
	assign rd_data = rf_reg[rd_addr];
endmodule : fsu_core_rf

//--- testbench/fsu_chk.sv
/*
 * Assertion checker for the float subtract unit, bound to its top module.
 * Assumes one clock and the synchronous active-high reset.
 */
module fsu_chk (
	input wire logic				SYS_CLK,
	input wire logic				RESET,
	input wire logic				ISSUE_VALID,
	input wire logic				ISSUE_QUERY,
	input wire logic [2:0]				ISSUE_SLOT,
	input wire logic				ISSUE_GUARD_LSB,
	input wire logic [fsu_pkg::FSU_DEST_W-1:0]	ISSUE_DEST,
	input wire logic				ISSUE_REJECT,
	input wire logic				WB_VALID,
	input wire logic [fsu_pkg::FSU_DEST_W-1:0]	WB_DEST,
	input wire logic [31:0]				WB_DATA,
	input wire logic				OTHER_FLAG_VALID,
	input wire logic [fsu_pkg::FSU_FLAG_W-1:0]	OTHER_FLAGS,
	input wire logic [fsu_pkg::FSU_FLAG_W-1:0]	STATUS_FLAGS,
	input wire logic				HSEL,
	input wire logic [fsu_pkg::FSU_ADDR_W-1:0]	HADDR,
	input wire logic [1:0]				HTRANS,
	input wire logic				HWRITE,
	input wire logic				HREADY
);
	timeunit 1ns;
	timeprecision 1ps;
	import fsu_pkg::*;
	logic	ok;
	logic	wr_pend;
	// status write in its data phase: the only time flags may fall
	always_ff @(posedge SYS_CLK)
		wr_pend <= !RESET && HSEL && HREADY && HTRANS[1] && HWRITE
			&& HADDR == FSU_OFF_STATUS;
	assign ok = ISSUE_VALID && ISSUE_GUARD_LSB
		&& (ISSUE_SLOT == FSU_SLOT_A || ISSUE_SLOT == FSU_SLOT_B);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	sequence s_sub; ok && !ISSUE_QUERY; endsequence
	sequence s_qry; ok && ISSUE_QUERY; endsequence
	sequence s_quiet; ISSUE_VALID && !(ok && !ISSUE_QUERY); endsequence
	////////////////////////////////////////////////////////////////////////
	wb_latency_a: assert property (
		ok |-> ##3 WB_VALID && WB_DEST == $past(ISSUE_DEST, 3))
		else $error("writeback late or wrong tag");
	no_writeback_a: assert property (
		!ok |-> ##3 !WB_VALID) else $error("writeback without issue");
	slot_reject_a: assert property (
		ISSUE_REJECT == (ISSUE_VALID && ISSUE_SLOT != FSU_SLOT_A
		&& ISSUE_SLOT != FSU_SLOT_B)) else $error("reject wrong");
	flags_sticky_a: assert property (
		!wr_pend |=> (STATUS_FLAGS & $past(STATUS_FLAGS))
		== $past(STATUS_FLAGS)) else $error("flag cleared");
	other_merge_a: assert property (
		OTHER_FLAG_VALID |=> (STATUS_FLAGS & $past(OTHER_FLAGS))
		== $past(OTHER_FLAGS)) else $error("other flags lost");
	quiet_status_a: assert property (
		s_quiet ##2 (!OTHER_FLAG_VALID && !wr_pend) |=> $stable(STATUS_FLAGS))
		else $error("status changed by quiet op");
	query_format_a: assert property (
		s_qry |-> ##3 WB_DATA[31:FSU_FLAG_W] == '0)
		else $error("flag vector upper bits set");
	result_flush_a: assert property (
		s_sub |-> ##3 (WB_DATA[30:23] != 8'h00 || WB_DATA[22:0] == 23'h0))
		else $error("denormal result delivered");
endmodule : fsu_chk

bind fsu_float_subtract_unit fsu_chk fsu_chk_inst (.SYS_CLK, .RESET,
	.ISSUE_VALID, .ISSUE_QUERY, .ISSUE_SLOT, .ISSUE_GUARD_LSB, .ISSUE_DEST,
	.ISSUE_REJECT, .WB_VALID, .WB_DEST, .WB_DATA, .OTHER_FLAG_VALID,
	.OTHER_FLAGS, .STATUS_FLAGS, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY);

//--- testbench/fsu_float_subtract_unit_tb.sv
/*
 * Self-checking bench for the float subtract unit: issue and AHB-Lite
 * tasks, a writeback scoreboard and a table of subtract cases.
 * Assumes the checker is bound and the register-file model is present.
 */
module fsu_float_subtract_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fsu_pkg::*;
	logic clk = 1'b0, rst = 1'b1, iv = 1'b0, iq = 1'b0, ig = 1'b1;
	logic ov = 1'b0, hsel = 1'b0, hw = 1'b0, rej, wbv, hro, hrsp;
	logic [2:0]		slot = FSU_SLOT_A;
	logic [FSU_DEST_W-1:0]	dest = '0, rf_a = '0, wbd;
	logic [FSU_FLAG_W-1:0]	of = '0, sf;
	logic [31:0]		a = '0, b = '0, hwd = '0, wbdat, hrd, rf_q, q, old;
	logic [11:0]		ha = '0;
	logic [1:0]		ht = '0;
	fsu_rmode_t		rm;
	logic [46:0]		e;
	logic [46:0]		exp_q[$];
	int			failures = 0, n_compared = 0, n_wb = 0, n_acc = 0;
	// rounding mode, minuend, subtrahend, difference, flags
	logic [111:0] tv [13] = '{
		112'h00_c0400000_3f800000_c0800000_00,
		112'h00_40400000_c0400000_40c00000_00,
		112'h00_40400000_00800000_40400000_02,
		112'h00_40400000_00400000_40400000_20,
		112'h00_00c00000_00800000_00000000_46,
		112'h00_7f800000_7f800000_ffffffff_10,
		112'h00_7f7fffff_ff7fffff_7f800000_0a,
		112'h00_ffffffff_3f800000_ffffffff_00,
		112'h00_ffbfffff_3f800000_ffffffff_10,
		112'h00_00800001_00800000_00000000_46,
		112'h01_7f7fffff_ff7fffff_7f7fffff_0a,
		112'h02_7f7fffff_ff7fffff_7f800000_0a,
		112'h03_3f800000_3f800000_80000000_00};

	fsu_float_subtract_unit fsu_float_subtract_unit_inst (
		.SYS_CLK(clk), .RESET(rst), .ISSUE_VALID(iv), .ISSUE_QUERY(iq),
		.ISSUE_SLOT(slot), .ISSUE_GUARD_LSB(ig), .ISSUE_DEST(dest),
		.FIRST_SOURCE(a), .SECOND_SOURCE(b), .ISSUE_REJECT(rej),
		.WB_VALID(wbv), .WB_DEST(wbd), .WB_DATA(wbdat),
		.OTHER_FLAG_VALID(ov), .OTHER_FLAGS(of), .STATUS_FLAGS(sf),
		.STATUS_ROUND_MODE(rm), .HSEL(hsel), .HADDR(ha), .HTRANS(ht),
		.HWRITE(hw), .HSIZE(3'h2), .HWDATA(hwd), .HREADY(hro),
		.HRDATA(hrd), .HREADYOUT(hro), .HRESP(hrsp));
	fsu_core_rf fsu_core_rf_inst (.clk(clk), .rst(rst), .wb_valid(wbv),
		.wb_dest(wbd), .wb_data(wbdat), .rd_addr(rf_a), .rd_data(rf_q));

	initial begin
		forever #12.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, exp, input string m);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	// address phase held until hready, then data phase likewise
	task automatic ahb(input logic w, input logic [11:0] ad,
			input logic [31:0] d, output logic [31:0] rd);
		hsel <= 1'b1;
		ht <= FSU_HTRANS_NONSEQ;
		ha <= ad;
		hw <= w;
		do @(posedge clk); while (hro !== 1'b1);
		hsel <= 1'b0;
		ht <= 2'h0;
		hwd <= d;
		do @(posedge clk); while (hro !== 1'b1);
		rd = hrd;
		chk({31'h0, hrsp}, {31'h0, FSU_HRESP_OKAY}, "response");
	endtask : ahb

	// valid stays high on return so back-to-back issues need no gap
	task automatic issue(input logic qy, g, input logic [2:0] s,
			input logic [111:0] tt);
		logic good;
		good = g && (s == FSU_SLOT_A || s == FSU_SLOT_B);
		iv <= 1'b1;
		iq <= qy;
		ig <= g;
		slot <= s;
		a <= tt[103:72];
		b <= tt[71:40];
		dest <= dest + 7'h1;
		if (good) begin
			n_acc++;
			exp_q.push_back({dest + 7'h1,
				qy ? {25'h0, tt[6:0]} : tt[39:8], tt[6:0], !qy});
		end
		#1;
		chk({31'h0, rej}, {31'h0, s != FSU_SLOT_A && s != FSU_SLOT_B},
			"reject");
		@(posedge clk);
	endtask : issue

	task automatic idle(input int n);
		iv <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle

	always @(posedge clk) begin
		if (!rst && wbv === 1'b1) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
			chk({25'h0, wbd}, {25'h0, e[46:40]}, "dest");
			chk(wbdat, e[39:8], "result");
			if (e[0])
				chk({25'h0, sf & e[7:1]}, {25'h0, e[7:1]}, "wb flags");
			n_wb++;
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		idle(1);
		ahb(1'b0, FSU_OFF_STATUS, 32'h0, q);
		chk(q, 32'h0, "status at reset");
		ahb(1'b0, FSU_OFF_COUNT, 32'h0, q);
		chk(q, FSU_COUNT_RST, "count at reset");
		foreach (tv[i]) begin
			ahb(1'b1, FSU_OFF_STATUS, {22'h0, tv[i][105:104], 8'h00}, q);
			issue(1'b0, 1'b1, FSU_SLOT_A, tv[i]);
			issue(1'b1, 1'b1, FSU_SLOT_B, tv[i]);
			idle(5);
			chk({25'h0, sf}, {25'h0, tv[i][6:0]}, "status");
			chk({30'h0, rm}, {30'h0, tv[i][105:104]}, "mode");
		end
		ahb(1'b0, FSU_OFF_STATUS, 32'h0, q);
		chk(q, {22'h0, FSU_RM_NEG, 8'h00}, "status readback");
		ahb(1'b1, FSU_OFF_STATUS, 32'h0, q);
		issue(1'b0, 1'b1, FSU_SLOT_A, tv[2]);
		idle(1);
		ov <= 1'b1;
		of <= 7'h01;
		idle(1);
		ov <= 1'b0;
		idle(4);
		chk({25'h0, sf}, 32'h3, "merged flags");
		issue(1'b0, 1'b1, FSU_SLOT_B, tv[0]);
		idle(5);
		chk({25'h0, sf}, 32'h3, "flags kept");
		rf_a <= dest + 7'h2;
		idle(1);
		old = rf_q;
		issue(1'b0, 1'b0, FSU_SLOT_A, tv[5]);
		issue(1'b1, 1'b0, FSU_SLOT_B, tv[5]);
		idle(5);
		chk({25'h0, sf}, 32'h3, "guarded flags");
		chk(rf_q, old, "guarded destination");
		for (int s = 0; s < 8; s++)
			issue(1'b0, 1'b1, 3'(s), tv[2]);
		idle(6);
		ahb(1'b1, FSU_OFF_COUNT, 32'hffff_ffff, q);
		ahb(1'b0, FSU_OFF_COUNT, 32'h0, q);
		chk(q, n_acc, "retired count");
		chk(n_wb, n_acc, "writeback count");
		ahb(1'b0, 12'h010, 32'h0, q);
		chk(q, 32'h0, "unmapped read");
		chk(exp_q.size(), 0, "missing writebacks");
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end
endmodule : fsu_float_subtract_unit_tb
